// [design/edo_ctrl_pkg.sv]
// constants, types and state codes for the edo page dram controller
// assumes a single 25 MHz clock and the slower -60 grade figures
`default_nettype none

package edo_ctrl_pkg;

    // *****************************************************
    // clock and conversion
    // *****************************************************
    localparam int CLK_PERIOD_NS = 40;

    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_max(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // *****************************************************
    // timing figures, ns unless named otherwise
    // *****************************************************
    localparam int T_RC_NS       = 110;
    localparam int T_RASP_NS     = 60;
    localparam int T_RASP_MAX_NS = 100000;
    localparam int T_PC_NS       = 40;
    localparam int T_PRWC_NS     = 56;
    localparam int T_RCD_NS      = 20;
    localparam int T_RCD_MAX_NS  = 45;
    localparam int T_RPC_NS      = 5;
    localparam int T_CRP_NS      = 5;
    localparam int T_CSR_NS      = 5;
    localparam int T_CHR_NS      = 10;
    localparam int T_WCR_NS      = 50;
    localparam int T_RWL_NS      = 15;
    localparam int T_WPZ_NS      = 10;
    localparam int T_OEH_NS      = 15;
    localparam int T_OEHC_NS     = 15;
    localparam int T_REF_MS      = 16;
    localparam int REF_ROWS      = 1024;
    localparam int T_PAUSE_US    = 200;
    localparam int INIT_CYCLES   = 8;

    // *****************************************************
    // derived cycle counts
    // *****************************************************
    localparam int RC_CYC   = cyc_min(T_RC_NS);
    localparam int RAS_CYC  = cyc_min(T_RASP_NS);
    localparam int RASP_CYC = cyc_max(T_RASP_MAX_NS);
    localparam int PC_CYC   = cyc_min(T_PC_NS);
    localparam int PRWC_CYC = cyc_min(T_PRWC_NS);
    localparam int RCD_CYC  = cyc_min(T_RCD_NS);
    localparam int RCDX_CYC = cyc_max(T_RCD_MAX_NS);
    localparam int RPC_CYC  = cyc_min(T_RPC_NS);
    localparam int CRP_CYC  = cyc_min(T_CRP_NS);
    localparam int CSR_CYC  = cyc_min(T_CSR_NS);
    localparam int CHR_CYC  = cyc_min(T_CHR_NS);
    localparam int WCR_CYC  = cyc_min(T_WCR_NS);
    localparam int RWL_CYC  = cyc_min(T_RWL_NS);
    localparam int WPZ_CYC  = cyc_min(T_WPZ_NS);
    localparam int OEH_CYC  = cyc_min(T_OEH_NS);
    localparam int OEHC_CYC = cyc_min(T_OEHC_NS);
    localparam int REF_INTERVAL_CYC =
        cyc_max(T_REF_MS * 1000000 / REF_ROWS);
    localparam int PAUSE_CYC = cyc_min(T_PAUSE_US * 1000);
    // close cycles needed after the page limit fires
    localparam int PAGE_MARGIN = 4;

    // *****************************************************
    // widths and types
    // *****************************************************
    localparam int ADDR_W = 10;
    localparam int DQ_W   = 16;
    localparam int LANE_W = 8;
    localparam int LANES  = 2;
    localparam int CNT_W  = 16;
    localparam int INIT_W = 4;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
        logic [LANES-1:0]  byte_en;
        logic [DQ_W-1:0]   wdata;
    } req_t;

    typedef struct packed {
        logic              ras_n;
        logic [LANES-1:0]  cas_n;
        logic              we_n;
        logic              oe_n;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0]   dq;
        logic              dq_oe;
    } pins_t;

    typedef enum logic [10:0] {
        S_PAUSE = 11'h001,
        S_IDLE  = 11'h002,
        S_ROW   = 11'h004,
        S_RAS   = 11'h008,
        S_COL   = 11'h010,
        S_CAS   = 11'h020,
        S_OPEN  = 11'h040,
        S_PRE   = 11'h080,
        S_RCAS  = 11'h100,
        S_RRAS  = 11'h200,
        S_RHLD  = 11'h400
    } state_t;

endpackage

`default_nettype wire

// [design/edo_span_counter.sv]
// down counter with load; done while it stands at zero
// assumes load and value come from the same clock domain
`default_nettype none

module edo_span_counter #(
    parameter int             W     = 16,
    parameter logic [W-1:0]   START = '0
)(
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // control
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_value,
    // status
    output var  logic         o_done
);

    logic [W-1:0] count;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            count <= START;
        else if (i_load)
            count <= i_value;
        else if (count != '0)
            count <= count - 1'b1;
    end

    assign o_done = (count == '0);

endmodule

`default_nettype wire

// [design/edo_tick_timer.sv]
// free divider giving a one-cycle pulse every PERIOD clocks
// assumes PERIOD fits the counter width chosen below
`default_nettype none

module edo_tick_timer #(
    parameter int PERIOD = 390
)(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // pulse
    output var  logic o_tick
);

    localparam int W = $clog2(PERIOD + 1);
    localparam logic [W-1:0] LAST = W'(PERIOD - 1);

    logic [W-1:0] count;

    if (PERIOD < 2)
        $error("tick period too short");

    assign o_tick = (count == LAST);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            count <= '0;
        else if (o_tick)
            count <= '0;
        else
            count <= count + 1'b1;
    end

endmodule

`default_nettype wire

// [design/edo_ctrl.sv]
// host controller driving an edo page dram through its pins
// assumes i_dq is synchronous to i_clk; pins registered once
`default_nettype none

module edo_ctrl #(
    parameter int PAUSE_CYCLES   = edo_ctrl_pkg::PAUSE_CYC,
    parameter int REFRESH_CYCLES = edo_ctrl_pkg::REF_INTERVAL_CYC,
    parameter int PAGE_CYCLES    = edo_ctrl_pkg::RASP_CYC
)(
    // clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_n,
    // request port
    input  wire logic                        i_req_valid,
    input  wire edo_ctrl_pkg::req_t          i_req,
    output logic                             o_req_ready,
    // read return
    output logic                             o_rd_valid,
    output logic [edo_ctrl_pkg::DQ_W-1:0]    o_rd_data,
    // status
    output logic                             o_init_done,
    // dram pins
    output logic                             o_ras_n,
    output logic                             o_lower_col_strobe_n,
    output logic                             o_upper_col_strobe_n,
    output logic                             o_we_n,
    output logic                             o_oe_n,
    output logic [edo_ctrl_pkg::ADDR_W-1:0]  o_addr,
    output logic [edo_ctrl_pkg::DQ_W-1:0]    o_dq,
    output logic                             o_dq_oe,
    input  wire logic [edo_ctrl_pkg::DQ_W-1:0] i_dq
);

    // *****************************************************
    // elaboration checks
    // *****************************************************
    // state spans the fixed sequence really provides
    localparam int SEQ_RC   = 4;
    localparam int SEQ_RAS  = 3;
    localparam int SEQ_PC   = 3;
    localparam int SEQ_RCD  = 2;
    localparam int SEQ_GAP  = 1;
    localparam int SEQ_WE   = 2;

    if (PAUSE_CYCLES < 1 || PAUSE_CYCLES >= (1 << edo_ctrl_pkg::CNT_W))
        $error("pause count out of range");
    if (REFRESH_CYCLES < 16 || REFRESH_CYCLES > edo_ctrl_pkg::REF_INTERVAL_CYC)
        $error("refresh interval out of range");
    if (PAGE_CYCLES <= 2 * edo_ctrl_pkg::PAGE_MARGIN
        || PAGE_CYCLES > edo_ctrl_pkg::RASP_CYC)
        $error("page limit out of range");
    if (edo_ctrl_pkg::RC_CYC > SEQ_RC)
        $error("row cycle too short for clock");
    if (edo_ctrl_pkg::RAS_CYC > SEQ_RAS)
        $error("row pulse too short for clock");
    if (edo_ctrl_pkg::PC_CYC > SEQ_PC || edo_ctrl_pkg::PRWC_CYC > SEQ_PC)
        $error("page cycle too short for clock");
    if (edo_ctrl_pkg::RCD_CYC > SEQ_RCD || edo_ctrl_pkg::RCDX_CYC < SEQ_RCD - 1)
        $error("row to column delay unmet");
    if (edo_ctrl_pkg::RPC_CYC > SEQ_GAP || edo_ctrl_pkg::CRP_CYC > SEQ_GAP)
        $error("strobe gap unmet");
    if (edo_ctrl_pkg::CSR_CYC > SEQ_GAP || edo_ctrl_pkg::CHR_CYC > SEQ_GAP)
        $error("refresh strobe order unmet");
    if (edo_ctrl_pkg::WCR_CYC > SEQ_RC - 1 || edo_ctrl_pkg::RWL_CYC > SEQ_WE
        || edo_ctrl_pkg::WPZ_CYC > SEQ_WE)
        $error("write strobe span unmet");
    if (edo_ctrl_pkg::OEH_CYC > SEQ_GAP || edo_ctrl_pkg::OEHC_CYC > SEQ_GAP)
        $error("output gate hold unmet");

    // *****************************************************
    // state and request holding
    // *****************************************************
    edo_ctrl_pkg::state_t state;
    edo_ctrl_pkg::state_t next_state;
    edo_ctrl_pkg::req_t   cur;
    edo_ctrl_pkg::pins_t  pins;
    edo_ctrl_pkg::pins_t  next_pins;

    logic [edo_ctrl_pkg::INIT_W-1:0] init_left;
    logic [edo_ctrl_pkg::DQ_W-1:0]   lane_data;
    logic                            ref_pend;

    wire pause_done;
    wire page_done;
    wire ref_tick;

    // *****************************************************
    // timers
    // *****************************************************
    // pause counts from reset only; a wake-up after an
    // overdue refresh repeats the eight cycles, not the pause
    edo_span_counter #(
        .W     (edo_ctrl_pkg::CNT_W),
        .START (edo_ctrl_pkg::CNT_W'(PAUSE_CYCLES))
    ) u_pause (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_load  (1'b0),
        .i_value ('0),
        .o_done  (pause_done)
    );

    wire page_load = (state == edo_ctrl_pkg::S_ROW);

    // margin leaves room to close the row before the limit
    edo_span_counter #(
        .W     (edo_ctrl_pkg::CNT_W),
        .START ('0)
    ) u_page (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_load  (page_load),
        .i_value (edo_ctrl_pkg::CNT_W'(PAGE_CYCLES - edo_ctrl_pkg::PAGE_MARGIN)),
        .o_done  (page_done)
    );

    edo_tick_timer #(
        .PERIOD (REFRESH_CYCLES)
    ) u_refresh (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .o_tick  (ref_tick)
    );

    // *****************************************************
    // decode
    // *****************************************************
    wire st_idle = (state == edo_ctrl_pkg::S_IDLE);
    wire st_row  = (state == edo_ctrl_pkg::S_ROW);
    wire st_ras  = (state == edo_ctrl_pkg::S_RAS);
    wire st_col  = (state == edo_ctrl_pkg::S_COL);
    wire st_cas  = (state == edo_ctrl_pkg::S_CAS);
    wire st_open = (state == edo_ctrl_pkg::S_OPEN);
    wire st_rcas = (state == edo_ctrl_pkg::S_RCAS);
    wire st_rras = (state == edo_ctrl_pkg::S_RRAS);
    wire st_rhld = (state == edo_ctrl_pkg::S_RHLD);

    wire init_done = (init_left == '0);
    wire row_hit   = (i_req.row == cur.row);
    wire overdue   = ref_tick && ref_pend;

    wire ready_idle = st_idle && !ref_pend;
    wire ready_page = st_open && row_hit && !ref_pend && !page_done;
    wire accept     = i_req_valid && o_req_ready;

    wire ras_low = st_ras || st_col || st_cas || st_open
                || st_rras || st_rhld;
    wire wr_phase = cur.write && (st_col || st_cas);
    wire refresh_cas = st_rcas || st_rras;
    wire use_row = st_row || st_ras;
    wire use_col = st_col || st_cas || st_open;

    // *****************************************************
    // next state
    // *****************************************************
    always_comb
    begin
        next_state = state;
        unique case (state)
            edo_ctrl_pkg::S_PAUSE:
                if (pause_done)
                    next_state = edo_ctrl_pkg::S_RCAS;
            edo_ctrl_pkg::S_IDLE:
                if (ref_pend || !init_done)
                    next_state = edo_ctrl_pkg::S_RCAS;
                else if (i_req_valid)
                    next_state = edo_ctrl_pkg::S_ROW;
            edo_ctrl_pkg::S_ROW:
                next_state = edo_ctrl_pkg::S_RAS;
            edo_ctrl_pkg::S_RAS:
                next_state = edo_ctrl_pkg::S_COL;
            edo_ctrl_pkg::S_COL:
                next_state = edo_ctrl_pkg::S_CAS;
            edo_ctrl_pkg::S_CAS:
                next_state = edo_ctrl_pkg::S_OPEN;
            edo_ctrl_pkg::S_OPEN:
                if (ref_pend || page_done)
                    next_state = edo_ctrl_pkg::S_PRE;
                else if (i_req_valid && row_hit)
                    next_state = edo_ctrl_pkg::S_COL;
                else if (i_req_valid)
                    next_state = edo_ctrl_pkg::S_PRE;
            edo_ctrl_pkg::S_PRE:
                if (ref_pend || !init_done)
                    next_state = edo_ctrl_pkg::S_RCAS;
                else
                    next_state = edo_ctrl_pkg::S_IDLE;
            edo_ctrl_pkg::S_RCAS:
                next_state = edo_ctrl_pkg::S_RRAS;
            edo_ctrl_pkg::S_RRAS:
                next_state = edo_ctrl_pkg::S_RHLD;
            edo_ctrl_pkg::S_RHLD:
                next_state = edo_ctrl_pkg::S_PRE;
        endcase
    end

    // *****************************************************
    // pin decode, registered one cycle later
    // *****************************************************
    // every pin lags the state by one clock, so all spans
    // keep their lengths and the pins stay glitch free
    for (genvar l = 0; l < edo_ctrl_pkg::LANES; l++)
    begin : g_lane
        localparam int LO = l * edo_ctrl_pkg::LANE_W;
        // lane l strobe gates only its own byte of data
        assign next_pins.cas_n[l] =
            !((st_cas && cur.byte_en[l]) || refresh_cas);
        assign lane_data[LO +: edo_ctrl_pkg::LANE_W] =
            cur.byte_en[l] ? i_dq[LO +: edo_ctrl_pkg::LANE_W]
                           : edo_ctrl_pkg::LANE_W'(0);
    end

    // column strobe rises with the row still high-to-low gap
    assign next_pins.ras_n = !ras_low;
    // write strobe falls with the column address, ahead of
    // the column strobe, and stays low through it
    assign next_pins.we_n  = !wr_phase;
    // output gate low only while a read strobe is low, and
    // never during writes or refresh
    assign next_pins.oe_n  = !(st_cas && !cur.write);
    assign next_pins.addr  = use_row ? cur.row :
                             use_col ? cur.col :
                             edo_ctrl_pkg::ADDR_W'(0);
    assign next_pins.dq    = cur.wdata;
    assign next_pins.dq_oe = wr_phase;

    // *****************************************************
    // registers
    // *****************************************************
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state <= edo_ctrl_pkg::S_PAUSE;
        else
            state <= next_state;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cur <= '0;
        else if (accept)
            cur <= i_req;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pins       <= '0;
            pins.ras_n <= 1'b1;
            pins.cas_n <= '1;
            pins.we_n  <= 1'b1;
            pins.oe_n  <= 1'b1;
        end
        else
            pins <= next_pins;
    end

    // a new tick wins over the clear of the served one
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ref_pend <= 1'b0;
        else if (ref_tick)
            ref_pend <= 1'b1;
        else if (st_rhld)
            ref_pend <= 1'b0;
    end

    // a tick finding the last one unserved means the
    // refresh period slipped: redo the wake-up cycles
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            init_left <= edo_ctrl_pkg::INIT_W'(edo_ctrl_pkg::INIT_CYCLES);
        else if (overdue)
            init_left <= edo_ctrl_pkg::INIT_W'(edo_ctrl_pkg::INIT_CYCLES);
        else if (st_rhld && !init_done)
            init_left <= init_left - 1'b1;
    end

    // sample at the end of the cycle whose pins hold a read
    wire rd_sample = !pins.oe_n;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rd_valid <= 1'b0;
            o_rd_data  <= '0;
        end
        else
        begin
            o_rd_valid <= rd_sample;
            if (rd_sample)
                o_rd_data <= lane_data;
        end
    end

    // *****************************************************
    // outputs
    // *****************************************************
    // refresh leaves the address at zero; the part uses its
    // own row counter then and ignores these pins
    assign o_ras_n              = pins.ras_n;
    assign o_lower_col_strobe_n = pins.cas_n[0];
    assign o_upper_col_strobe_n = pins.cas_n[1];
    assign o_we_n               = pins.we_n;
    assign o_oe_n               = pins.oe_n;
    assign o_addr               = pins.addr;
    assign o_dq                 = pins.dq;
    assign o_dq_oe              = pins.dq_oe;
    assign o_req_ready          = ready_idle || ready_page;
    assign o_init_done          = init_done;

endmodule

`default_nettype wire

// [sim/edo_ctrl_chk.sv]
// pin timing checker for the edo dram controller
// assumes a bind onto edo_ctrl and one clock domain
`default_nettype none

module edo_ctrl_chk #(
    parameter int PAUSE_CYCLES   = 20,
    parameter int REFRESH_CYCLES = 64,
    parameter int PAGE_CYCLES    = 40
)(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // watched outputs
    input  wire logic o_init_done,
    input  wire logic o_ras_n,
    input  wire logic o_lower_col_strobe_n,
    input  wire logic o_upper_col_strobe_n,
    input  wire logic o_we_n,
    input  wire logic o_oe_n,
    input  wire logic o_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // helpers
    // ****************
    wire logic        cas_n = o_lower_col_strobe_n & o_upper_col_strobe_n;
    logic      [15:0] low_cnt;
    logic      [15:0] since_rst;
    logic      [15:0] ref_gap;

    // only a refresh shows column low with the row high, so
    // ordinary accesses cannot restart the refresh gap
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            low_cnt   <= 16'h0;
            since_rst <= 16'h0;
            ref_gap   <= 16'h0;
        end
        else
        begin
            low_cnt   <= o_ras_n ? 16'h0 : low_cnt + 16'h1;
            since_rst <= (&since_rst) ? since_rst : since_rst + 16'h1;
            ref_gap   <= (o_ras_n && !cas_n) ? 16'h0 : ref_gap + 16'h1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_row_cycle: assert property (
        $fell(o_ras_n) |=> !o_ras_n ##1 !$fell(o_ras_n))
        else $error("row strobe cycle too short");
    chk_page_limit: assert property (
        low_cnt <= PAGE_CYCLES) else $error("row strobe low too long");
    chk_col_delay: assert property (
        $fell(o_ras_n) && cas_n |=> cas_n) else $error("column strobe too early");
    chk_cas_ras_gap: assert property (
        $fell(o_ras_n) |-> !$rose(o_lower_col_strobe_n) && !$rose(o_upper_col_strobe_n))
        else $error("column rise with row fall");
    chk_refresh_setup: assert property (
        $fell(o_ras_n) && !cas_n |-> !$past(o_lower_col_strobe_n)
        && !$past(o_upper_col_strobe_n) && !o_lower_col_strobe_n)
        else $error("refresh strobe order");
    chk_refresh_gap: assert property (
        o_init_done |-> ref_gap <= 2 * REFRESH_CYCLES) else $error("refresh late");
    chk_early_write: assert property (
        $fell(cas_n) && !o_we_n |-> !$past(o_we_n) && o_dq_oe && o_oe_n)
        else $error("write strobe after column");
    chk_we_hold: assert property (
        $rose(o_we_n) |-> !$past(o_ras_n) && !$past(o_ras_n, 2))
        else $error("write strobe released early");
    chk_we_lead: assert property (
        $fell(o_we_n) |-> !o_ras_n ##1 !o_ras_n) else $error("write lead short");
    chk_oe_hold: assert property (
        $rose(cas_n) |-> o_oe_n ##1 o_oe_n) else $error("output gate low early");
    chk_pause_first: assert property (
        $fell(o_ras_n) |-> since_rst >= PAUSE_CYCLES) else $error("pause cut short");
endmodule

bind edo_ctrl edo_ctrl_chk #(
    .PAUSE_CYCLES   (PAUSE_CYCLES),
    .REFRESH_CYCLES (REFRESH_CYCLES),
    .PAGE_CYCLES    (PAGE_CYCLES)
) chk_i (
    .i_clk                (i_clk),
    .i_rst_n              (i_rst_n),
    .o_init_done          (o_init_done),
    .o_ras_n              (o_ras_n),
    .o_lower_col_strobe_n (o_lower_col_strobe_n),
    .o_upper_col_strobe_n (o_upper_col_strobe_n),
    .o_we_n               (o_we_n),
    .o_oe_n               (o_oe_n),
    .o_dq_oe              (o_dq_oe)
);

`default_nettype wire

// [sim/edo_dram_model.sv]
// behavioural edo page dram, 16 rows by 16 columns kept
// assumes pins from edo_ctrl; the clock only paces the float pattern
`default_nettype none

module edo_dram_model (
    // pins
    input  wire logic        i_clk,
    input  wire logic        i_ras_n,
    input  wire logic [1:0]  i_cas_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic [9:0]  i_addr,
    input  wire logic [15:0] i_d,
    output logic      [15:0] o_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // storage
    // ****************
    logic [15:0] mem [0:255];
    logic [3:0]  row;
    logic [3:0]  col [0:1];
    logic [1:0]  lane_on = 2'b00;
    logic [15:0] flt     = 16'h5a5a;

    // floating pins change every cycle so no stale value can match
    always @(posedge i_clk)
        flt <= ~flt;
    always @(negedge i_ras_n)
        if (&i_cas_n)
            row <= i_addr[3:0];

    for (genvar i = 0; i < 2; i++)
    begin : g_lane
        always @(negedge i_cas_n[i] or posedge i_ras_n)
            if (i_ras_n)
                lane_on[i] <= 1'b0;
            else if (!i_we_n)
                mem[{row, i_addr[3:0]}][8*i +: 8] <= i_d[8*i +: 8];
            else
            begin
                col[i]     <= #5 i_addr[3:0];
                lane_on[i] <= 1'b1;
            end
        assign o_q[8*i +: 8] = (lane_on[i] && !i_oe_n && i_we_n)
            ? mem[{row, col[i]}][8*i +: 8] : flt[8*i +: 8];
    end
endmodule

`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the edo dram controller
// assumes the checker and dram model files are compiled first
`default_nettype none

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
    $display("unexpected %0t: got %h want %h", $time, a, b); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // signals
    // ****************
    logic               i_clk       = 1'b0;
    logic               i_rst_n     = 1'b0;
    logic               i_req_valid = 1'b0;
    edo_ctrl_pkg::req_t i_req       = '0;
    logic               o_req_ready, o_rd_valid, o_init_done;
    logic               ras, lower_col_strobe_n, upper_col_strobe_n, we, oe, dq_oe;
    logic [15:0]        o_rd_data, dq, q;
    logic [9:0]         addr;
    wire logic [15:0]   bus = dq_oe ? dq : q;
    int                 bad_count = 0;
    int                 checks = 0;
    int                 cyc = 0;
    int                 refs = 0;

    edo_ctrl #(.PAUSE_CYCLES(20), .REFRESH_CYCLES(64), .PAGE_CYCLES(40)) uut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid),
        .i_req(i_req), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .o_init_done(o_init_done), .o_ras_n(ras),
        .o_lower_col_strobe_n(lower_col_strobe_n), .o_upper_col_strobe_n(upper_col_strobe_n), .o_we_n(we),
        .o_oe_n(oe), .o_addr(addr), .o_dq(dq), .o_dq_oe(dq_oe), .i_dq(bus));
    edo_dram_model dram (.i_clk(i_clk), .i_ras_n(ras), .i_cas_n({upper_col_strobe_n, lower_col_strobe_n}),
        .i_we_n(we), .i_oe_n(oe), .i_addr(addr), .i_d(bus), .o_q(q));

    initial
        forever #20 i_clk = ~i_clk;
    always @(negedge ras)
        if (!lower_col_strobe_n)
            refs++;
    // hang guard, far above the several hundred cycles the run needs
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    // ****************
    // tasks
    // ****************
    task automatic send(input logic w, input logic [9:0] r, input logic [9:0] c,
                        input logic [1:0] be, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        #1;
        i_req_valid = 1'b1;
        i_req = '{w, r, c, be, d};
        do
        begin
            @(posedge i_clk);
            n++;
        end while (o_req_ready !== 1'b1 && n < 300);
        `CHK(o_req_ready, 1'b1)
        #1;
        i_req_valid = 1'b0;
    endtask

    task automatic rd(input logic [9:0] r, input logic [9:0] c, input logic [1:0] be,
                      input logic [15:0] exp);
        int n;
        n = 0;
        send(1'b0, r, c, be, 16'h0);
        while (o_rd_valid !== 1'b1 && n < 20)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        `CHK(o_rd_valid, 1'b1)
        `CHK(o_rd_data, exp)
    endtask

    task automatic do_reset();
        int n;
        n = 0;
        i_rst_n = 1'b0;
        refs = 0;
        repeat (5) @(posedge i_clk);
        `CHK({ras, lower_col_strobe_n, upper_col_strobe_n, we, oe, dq_oe, o_req_ready, o_rd_valid}, 8'hf8)
        #1;
        i_rst_n = 1'b1;
        while (o_init_done !== 1'b1 && n < 200)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        `CHK(o_init_done, 1'b1)
        `CHK(refs, 8)
    endtask

    task automatic s_page();
        for (int i = 0; i < 16; i++)
            send(1'b1, 10'h3, 10'(i), 2'h3, {12'h3c0, 4'(i)});
        for (int i = 0; i < 16; i++)
            rd(10'h3, 10'(i), 2'h3, {12'h3c0, 4'(i)});
    endtask

    task automatic s_lanes();
        send(1'b1, 10'h5, 10'h1, 2'h3, 16'ha5c3);
        send(1'b1, 10'h5, 10'h1, 2'h1, 16'hffee);
        rd(10'h5, 10'h1, 2'h3, 16'ha5ee);
        rd(10'h5, 10'h1, 2'h2, 16'ha500);
        rd(10'h5, 10'h1, 2'h1, 16'h00ee);
        rd(10'h3, 10'h2, 2'h3, 16'h3c02);
    endtask

    task automatic s_refresh();
        int r0;
        r0 = refs;
        repeat (192) @(posedge i_clk);
        `CHK(refs - r0 >= 2, 1'b1)
        rd(10'h3, 10'hf, 2'h3, 16'h3c0f);
    endtask

    task automatic s_midreset();
        send(1'b0, 10'h5, 10'h1, 2'h3, 16'h0);
        do_reset();
        rd(10'h5, 10'h1, 2'h3, 16'ha5ee);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        do_reset();
        s_page();
        s_lanes();
        s_refresh();
        s_midreset();
        tally_and_finish();
    end
endmodule

`default_nettype wire
